/* common/axis_status_pkg.sv */
// shared types and constants for the axis status word block
package axis_status_pkg;
    localparam int STATUS_W = 16;
    localparam logic [STATUS_W-1:0] STATUS_RST = 16'h0000;
    localparam int BIT_EMG = 15;
    localparam int BIT_READY = 14;
    localparam int BIT_ZONE2 = 13;
    localparam int BIT_ZONE1 = 12;
    localparam int BIT_PZONE = 11;
    localparam int BIT_TEACH = 10;
    localparam int BIT_RDDONE = 9;
    localparam int BIT_MFIN = 8;
    localparam int BIT_MINOR = 7;
    localparam int BIT_LOAD = 6;
    localparam int BIT_PMISS = 5;
    localparam int BIT_SERVO = 4;
    localparam int BIT_FAULT = 3;
    localparam int BIT_MOVE = 2;
    localparam int BIT_HOMED = 1;
    localparam int BIT_INPOS = 0;
    localparam logic FLAG_ON = 1'b1;
    localparam logic FLAG_OFF = 1'b0;
    localparam logic [31:0] WIDTH_MAX = 32'h000F423F;
    localparam logic [15:0] SPEED_MIN = 16'h0001;
    localparam logic [15:0] ACCEL_MIN = 16'h0001;
    localparam logic [15:0] ACCEL_MAX = 16'h012C;
    localparam logic [15:0] PRESS_MAX = 16'h00FF;
    localparam logic [31:0] WORD32_RST = 32'h00000000;
    localparam logic [15:0] WORD16_RST = 16'h0000;

    typedef enum logic {PRESS_METHOD_A, PRESS_METHOD_B} press_method_t;

    typedef struct packed {
        logic [31:0] target;
        logic [31:0] width;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] press_cur;
        press_method_t press_method;
        logic press;
    } move_cmd_t;

    typedef struct packed {
        logic pos_done;
        logic home_done;
        logic press_done;
        logic press_fail;
        logic move_start;
        logic read_done;
        logic read_req;
    } axis_ev_t;

    typedef struct packed {
        logic servo_on;
        logic alarm;
        logic moving;
        logic overload_warn;
        logic msg_error;
        logic load_ok;
        logic home_lost;
        logic emg_stop;
        logic ready;
        logic teach;
        logic zone1;
        logic zone2;
        logic pzone;
    } axis_lvl_t;

    typedef struct packed {
        logic [31:0] target;
        logic [31:0] width;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] press_cur;
        press_method_t press_method;
        logic press;
    } axis_drive_t;
endpackage

/* verilog/axis_status_word_direct_mode.sv */
// status word builder and direct-value command path for one axis
// Summary of operation
// - every flag reads 1 when on and 0 when off.
// - data-read-done flag, bit 9, sets when a read finishes.
// - motion-finished, bit 8, sets on any completion or press fail; clears at move start.
// - motion-finished is held at zero while the servo is off.
// - minor-alarm, bit 7, set on overload warning or message-level error.
// - force-judgement, bit 6, follows whether the load criterion is achieved.
// - press-miss, bit 5, sets when pressing ends without touching the workpiece.
// - servo-on, bit 4, set once standby is finished and servo energised.
// - fault, bit 3, stays set while an alarm is active.
// - moving, bit 2, set throughout motion.
// - homed, bit 1, sets at homing done, holds until home reference lost.
// - in-position, bit 0, sets at positioning done, holds stopped with servo on.
// - one shared acceleration/deceleration value only.
// - in direct mode, zone flags 1 and 2 count only once their ranges are configured, and the position zone flag reads 0.
// - commanded speed may change while a move is in progress.
// - pressing offers a choice between two pressing methods.
// - emergency-stop flag, bit 15, set during an emergency stop.
`timescale 1ns/100ps
`default_nettype none
module axis_status_word_direct_mode (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic DIRECT_MODE,
    input wire logic ZONE1_CFG,
    input wire logic ZONE2_CFG,
    input wire axis_status_pkg::axis_ev_t AXIS_EV,
    input wire axis_status_pkg::axis_lvl_t AXIS_LVL,
    input wire logic CMD_VALID,
    input wire axis_status_pkg::move_cmd_t CMD,
    input wire logic SPEED_WR,
    input wire logic [15:0] SPEED_VAL,
    output logic [15:0] STATUS_WORD,
    output axis_status_pkg::axis_drive_t DRIVE,
    output logic MOVE_GO,
    output logic SPEED_UPD,
    output logic CMD_ERR
);
    import axis_status_pkg::*;

    logic rd_done_r;
    logic rd_done_nxt;
    logic mfin_r;
    logic mfin_nxt;
    logic pmiss_r;
    logic pmiss_nxt;
    logic homed_r;
    logic homed_nxt;
    logic inpos_r;
    logic inpos_nxt;
    logic minor_nxt;
    logic emg_nxt;
    logic load_nxt;
    logic servo_nxt;
    logic fault_nxt;
    logic move_nxt;
    logic zone1_nxt;
    logic zone2_nxt;
    logic pzone_nxt;
    logic any_done;
    logic cmd_ok;
    logic speed_ok;
    logic [15:0] word_nxt;

    // read completion sticks until the next read is requested; set wins
    always_comb begin
        rd_done_nxt = rd_done_r;
        if (AXIS_EV.read_req) begin
            rd_done_nxt = FLAG_OFF;
        end
        if (AXIS_EV.read_done) begin
            rd_done_nxt = FLAG_ON;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_done_r <= FLAG_OFF;
        end else begin
            rd_done_r <= rd_done_nxt;
        end
    end

    assign any_done = AXIS_EV.pos_done | AXIS_EV.home_done
                    | AXIS_EV.press_done | AXIS_EV.press_fail;

    // a completion in the same cycle as a move start is kept
    always_comb begin
        mfin_nxt = mfin_r;
        if (AXIS_EV.move_start) begin
            mfin_nxt = FLAG_OFF;
        end
        if (any_done) begin
            mfin_nxt = FLAG_ON;
        end
        if (!AXIS_LVL.servo_on) begin
            mfin_nxt = FLAG_OFF;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mfin_r <= FLAG_OFF;
        end else begin
            mfin_r <= mfin_nxt;
        end
    end

    // press miss lasts until the next movement starts
    always_comb begin
        pmiss_nxt = pmiss_r;
        if (AXIS_EV.move_start) begin
            pmiss_nxt = FLAG_OFF;
        end
        if (AXIS_EV.press_fail) begin
            pmiss_nxt = FLAG_ON;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pmiss_r <= FLAG_OFF;
        end else begin
            pmiss_r <= pmiss_nxt;
        end
    end

    always_comb begin
        homed_nxt = homed_r;
        if (AXIS_LVL.home_lost) begin
            homed_nxt = FLAG_OFF;
        end
        if (AXIS_EV.home_done) begin
            homed_nxt = FLAG_ON;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            homed_r <= FLAG_OFF;
        end else begin
            homed_r <= homed_nxt;
        end
    end

    // a failed press never reports in-position, even with press_done beside it
    always_comb begin
        inpos_nxt = inpos_r;
        if (AXIS_EV.move_start || !AXIS_LVL.servo_on) begin
            inpos_nxt = FLAG_OFF;
        end
        if (AXIS_EV.pos_done
            || (AXIS_EV.press_done && !AXIS_EV.press_fail)) begin
            inpos_nxt = FLAG_ON;
        end
        if (AXIS_EV.press_fail || !AXIS_LVL.servo_on) begin
            inpos_nxt = FLAG_OFF;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            inpos_r <= FLAG_OFF;
        end else begin
            inpos_r <= inpos_nxt;
        end
    end

    assign minor_nxt = AXIS_LVL.overload_warn | AXIS_LVL.msg_error;
    // level bits keep no memory of their own, they mirror the axis
    assign emg_nxt = AXIS_LVL.emg_stop;
    assign load_nxt = AXIS_LVL.load_ok;
    assign servo_nxt = AXIS_LVL.servo_on;
    assign fault_nxt = AXIS_LVL.alarm;
    assign move_nxt = AXIS_LVL.moving;
    // in direct mode unconfigured zones would report a meaningless range, so they read off
    assign zone1_nxt = AXIS_LVL.zone1 & (ZONE1_CFG | !DIRECT_MODE);
    assign zone2_nxt = AXIS_LVL.zone2 & (ZONE2_CFG | !DIRECT_MODE);
    assign pzone_nxt = AXIS_LVL.pzone & !DIRECT_MODE;

    // word built from next values so flags and word change on the same edge
    always_comb begin
        word_nxt = STATUS_RST;
        word_nxt[BIT_EMG] = emg_nxt;
        word_nxt[BIT_READY] = AXIS_LVL.ready;
        word_nxt[BIT_ZONE2] = zone2_nxt;
        word_nxt[BIT_ZONE1] = zone1_nxt;
        word_nxt[BIT_PZONE] = pzone_nxt;
        word_nxt[BIT_TEACH] = AXIS_LVL.teach;
        word_nxt[BIT_RDDONE] = rd_done_nxt;
        word_nxt[BIT_MFIN] = mfin_nxt;
        word_nxt[BIT_MINOR] = minor_nxt;
        word_nxt[BIT_LOAD] = load_nxt;
        word_nxt[BIT_PMISS] = pmiss_nxt;
        word_nxt[BIT_SERVO] = servo_nxt;
        word_nxt[BIT_FAULT] = fault_nxt;
        word_nxt[BIT_MOVE] = move_nxt;
        word_nxt[BIT_HOMED] = homed_nxt;
        word_nxt[BIT_INPOS] = inpos_nxt;
    end

    // a single register stage: every bit shows one edge after its cause
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            STATUS_WORD <= STATUS_RST;
        end else begin
            STATUS_WORD <= word_nxt;
        end
    end

    // range checks of the numeric command words, one each for width, speed, accel and press current; target is unchecked
    logic width_ok;
    logic speed_min_ok;
    logic accel_ok;
    logic press_ok;
    logic cmd_take;
    logic speed_take;
    logic err_set;
    logic err_clr;
    // profile registers; the drive output is only their concatenation
    logic [31:0] target_r;
    logic [31:0] width_r;
    logic [15:0] speed_r;
    logic [15:0] accel_r;
    logic [15:0] press_cur_r;
    press_method_t press_method_r;
    logic press_r;

    assign width_ok = CMD.width <= WIDTH_MAX;
    assign speed_min_ok = CMD.speed >= SPEED_MIN;
    assign accel_ok = (CMD.accel >= ACCEL_MIN) && (CMD.accel <= ACCEL_MAX);
    assign press_ok = CMD.press_cur <= PRESS_MAX;
    assign cmd_ok = width_ok && speed_min_ok && accel_ok && press_ok;
    assign speed_ok = SPEED_VAL >= SPEED_MIN;

    // out-of-range commands are dropped whole rather than clamped,
    // so the axis never runs on a half-updated profile
    assign cmd_take = CMD_VALID && cmd_ok && DIRECT_MODE;
    // a full command wins over a lone speed write in the same cycle
    assign speed_take = SPEED_WR && speed_ok && DIRECT_MODE && !cmd_take;
    // a bad word in either path raises the error, any other word lowers it
    assign err_set = (CMD_VALID && !cmd_ok) || (SPEED_WR && !speed_ok);
    assign err_clr = CMD_VALID || SPEED_WR;

    // profile words hold until the next accepted command; speed also takes accepted speed writes
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            target_r <= WORD32_RST;
        end else if (cmd_take) begin
            target_r <= CMD.target;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            width_r <= WORD32_RST;
        end else if (cmd_take) begin
            width_r <= CMD.width;
        end
    end

    // speed alone may be rewritten, also in the middle of a move
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            speed_r <= WORD16_RST;
        end else if (cmd_take) begin
            speed_r <= CMD.speed;
        end else if (speed_take) begin
            speed_r <= SPEED_VAL;
        end
    end

    // decel has no register of its own, so the two ramps cannot differ
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            accel_r <= WORD16_RST;
        end else if (cmd_take) begin
            accel_r <= CMD.accel;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            press_cur_r <= WORD16_RST;
        end else if (cmd_take) begin
            press_cur_r <= CMD.press_cur;
        end
    end

    // method and press flag travel with the rest of the profile
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            press_method_r <= PRESS_METHOD_A;
        end else if (cmd_take) begin
            press_method_r <= CMD.press_method;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            press_r <= FLAG_OFF;
        end else if (cmd_take) begin
            press_r <= CMD.press;
        end
    end

    assign DRIVE = {target_r, width_r, speed_r, accel_r, accel_r,
                    press_cur_r, press_method_r, press_r};

    // one strobe per accepted command
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MOVE_GO <= FLAG_OFF;
        end else begin
            MOVE_GO <= cmd_take;
        end
    end

    // at rest a new speed just waits for the next move, so no strobe
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SPEED_UPD <= FLAG_OFF;
        end else begin
            SPEED_UPD <= speed_take && AXIS_LVL.moving;
        end
    end

    // error stays up until a good command or speed write arrives, even one not taken outside direct mode
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CMD_ERR <= FLAG_OFF;
        end else if (err_set) begin
            CMD_ERR <= FLAG_ON;
        end else if (err_clr) begin
            CMD_ERR <= FLAG_OFF;
        end
    end
endmodule
`default_nettype wire

/* tb/axis_status_checker.sv */
// port-level assertions for the axis status word block
`timescale 1ns/100ps
`default_nettype none
module axis_status_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic DIRECT_MODE,
    input wire axis_status_pkg::axis_ev_t AXIS_EV,
    input wire axis_status_pkg::axis_lvl_t AXIS_LVL,
    input wire logic CMD_VALID,
    input wire logic SPEED_WR,
    input wire logic [15:0] SPEED_VAL,
    input wire logic [15:0] STATUS_WORD,
    input wire axis_status_pkg::axis_drive_t DRIVE,
    input wire logic MOVE_GO,
    input wire logic SPEED_UPD
);
    import axis_status_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_read_done_set: assert property (AXIS_EV.read_done |=> STATUS_WORD[BIT_RDDONE])
        else $error("read done flag missing");
    a_motion_fin_set: assert property ((AXIS_EV.pos_done || AXIS_EV.home_done || AXIS_EV.press_done
        || AXIS_EV.press_fail) && AXIS_LVL.servo_on |=> STATUS_WORD[BIT_MFIN]) else $error("motion end missing");
    a_motion_fin_servo: assert property (!AXIS_LVL.servo_on |=> !STATUS_WORD[BIT_MFIN])
        else $error("motion end set with servo off");
    a_minor_alarm_set: assert property (AXIS_LVL.overload_warn || AXIS_LVL.msg_error |=> STATUS_WORD[BIT_MINOR])
        else $error("minor alarm missing");
    a_load_follow: assert property (1'b1 |=> STATUS_WORD[BIT_LOAD] == $past(AXIS_LVL.load_ok))
        else $error("load flag wrong");
    a_press_miss_set: assert property (AXIS_EV.press_fail |=> STATUS_WORD[BIT_PMISS] && !STATUS_WORD[BIT_INPOS])
        else $error("press miss handling wrong");
    a_servo_follow: assert property (1'b1 |=> STATUS_WORD[BIT_SERVO] == $past(AXIS_LVL.servo_on))
        else $error("servo flag wrong");
    a_homed_hold: assert property (STATUS_WORD[BIT_HOMED] && !AXIS_LVL.home_lost |=> STATUS_WORD[BIT_HOMED])
        else $error("homed flag dropped");
    a_pzone_zero: assert property (DIRECT_MODE |=> !STATUS_WORD[BIT_PZONE])
        else $error("position zone set in direct mode");
    a_accel_pair: assert property (MOVE_GO |-> DRIVE.decel == DRIVE.accel && DRIVE.accel <= ACCEL_MAX)
        else $error("decel differs from accel");
    a_speed_change: assert property (SPEED_WR && !CMD_VALID && DIRECT_MODE && SPEED_VAL != 16'h0000
        && AXIS_LVL.moving |=> SPEED_UPD && DRIVE.speed == $past(SPEED_VAL)) else $error("speed change lost");
endmodule
bind axis_status_word_direct_mode axis_status_checker axis_status_checker_i (.CLK(CLK), .SYS_RST(SYS_RST),
    .DIRECT_MODE(DIRECT_MODE), .AXIS_EV(AXIS_EV), .AXIS_LVL(AXIS_LVL), .CMD_VALID(CMD_VALID),
    .SPEED_WR(SPEED_WR), .SPEED_VAL(SPEED_VAL), .STATUS_WORD(STATUS_WORD), .DRIVE(DRIVE),
    .MOVE_GO(MOVE_GO), .SPEED_UPD(SPEED_UPD));
`default_nettype wire

/* tb/plc_model.sv */
// fieldbus master model writing direct-value command words
`timescale 1ns/100ps
`default_nettype none
module plc_model (
    input wire logic clk,
    output logic cmd_valid,
    output axis_status_pkg::move_cmd_t cmd,
    output logic speed_wr,
    output logic [15:0] speed_val
);
    import axis_status_pkg::*;
    initial begin
        {cmd_valid, speed_wr} = 2'b00;
        cmd = '0;
        speed_val = 16'h0000;
    end
    // every number goes out whole, with one shared accel value
    task automatic issue_cmd(input move_cmd_t c);
        @(negedge clk);
        cmd <= c;
        cmd_valid <= 1'b1;
        @(negedge clk);
        cmd_valid <= 1'b0;
        cmd <= ~c; // released words must not look valid by accident
    endtask
    task automatic write_speed(input logic [15:0] v);
        @(negedge clk);
        speed_val <= v;
        speed_wr <= 1'b1;
        @(negedge clk);
        speed_wr <= 1'b0;
        speed_val <= ~v;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the axis status word block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import axis_status_pkg::*;
    logic clk, sys_rst, direct_mode, z1_cfg, z2_cfg, cmd_valid, speed_wr, move_go, speed_upd, cmd_err;
    axis_ev_t ev;
    axis_lvl_t lvl;
    move_cmd_t cmd, c;
    axis_drive_t drive, exp_d;
    logic [15:0] speed_val, status_word, msk, val, spd_w;
    int fail_count = 0;
    int cmp_count = 0;
    // event, servo, home lost, mask, expected
    logic [40:0] tab [7] = '{{7'h40, 2'b10, 32'h01010101}, {7'h04, 2'b10, 32'h01010000},
        {7'h08, 2'b10, 32'h01210120}, {7'h20, 2'b10, 32'h00020002}, {7'h00, 2'b11, 32'h00020000},
        {7'h02, 2'b10, 32'h02000200}, {7'h40, 2'b00, 32'h01110000}};
    axis_status_word_direct_mode axis_status_word_direct_mode_i (.CLK(clk), .SYS_RST(sys_rst),
        .DIRECT_MODE(direct_mode), .ZONE1_CFG(z1_cfg), .ZONE2_CFG(z2_cfg), .AXIS_EV(ev), .AXIS_LVL(lvl),
        .CMD_VALID(cmd_valid), .CMD(cmd), .SPEED_WR(speed_wr), .SPEED_VAL(speed_val),
        .STATUS_WORD(status_word), .DRIVE(drive), .MOVE_GO(move_go), .SPEED_UPD(speed_upd), .CMD_ERR(cmd_err));
    plc_model plc_i (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .speed_wr(speed_wr), .speed_val(speed_val));
    always #2 clk = ~clk;
    function automatic logic [15:0] lvl_exp(input axis_lvl_t l, input logic dm, input logic z1, input logic z2);
        return {l.emg_stop, l.ready, l.zone2 & (z2 | ~dm), l.zone1 & (z1 | ~dm), l.pzone & ~dm, l.teach,
            2'b00, l.overload_warn | l.msg_error, l.load_ok, 1'b0, l.servo_on, l.alarm, l.moving, 2'b00};
    endfunction
    function automatic move_cmd_t rnd_cmd(input logic top);
        rnd_cmd.target = $urandom;
        rnd_cmd.width = top ? WIDTH_MAX : $urandom % 32'd1000000;
        rnd_cmd.speed = 16'($urandom % 65535 + 1);
        rnd_cmd.accel = top ? ACCEL_MAX : 16'($urandom % 300 + 1);
        rnd_cmd.press_cur = top ? PRESS_MAX : {8'h00, 8'($urandom)};
        rnd_cmd.press_method = press_method_t'(top);
        rnd_cmd.press = 1'b1;
    endfunction
    function automatic axis_drive_t drive_exp(input move_cmd_t m);
        return {m.target, m.width, m.speed, m.accel, m.accel, m.press_cur, m.press_method, m.press};
    endfunction
    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        {clk, sys_rst, direct_mode, z1_cfg, z2_cfg} = 5'b01000;
        ev = '0;
        lvl = '0;
        void'($urandom(93896));
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (60) begin
            {lvl, direct_mode, z1_cfg, z2_cfg} = 16'($urandom);
            @(negedge clk);
            chk(status_word & 16'hFCDC, lvl_exp(lvl, direct_mode, z1_cfg, z2_cfg));
        end
        lvl = '0;
        foreach (tab[k]) begin
            {ev, lvl.servo_on, lvl.home_lost, msk, val} = tab[k];
            @(negedge clk);
            ev = '0;
            chk(status_word & msk, val);
        end
        direct_mode = 1'b1;
        lvl.servo_on = 1'b1;
        lvl.moving = 1'b1;
        for (int m = 0; m < 2; m++) begin
            c = rnd_cmd(m[0]);
            plc_i.issue_cmd(c);
            exp_d = drive_exp(c);
            chk({move_go, cmd_err, drive}, {2'b10, exp_d});
        end
        // one past the accel span must be refused without touching the drive
        c.accel = ACCEL_MAX + 16'h0001;
        plc_i.issue_cmd(c);
        chk({move_go, cmd_err, drive}, {2'b01, exp_d});
        spd_w = 16'($urandom) | 16'h0001;
        plc_i.write_speed(spd_w);
        chk({speed_upd, drive.speed}, {1'b1, spd_w});
        final_report();
    end
endmodule
`default_nettype wire
